// *** hw/vrc_pkg.sv ***
package vrc_pkg;

   // Serial command word layout, first bit on the wire is bit 0
   localparam int CMD_W      = 16;
   localparam int ADDR_W     = 10;
   localparam int ADDR_LSB   = 0;
   localparam int C_MC       = 11;   // message_cue_bit
   localparam int C_IAB      = 12;   // ignore_address_bit
   localparam int C_PU       = 13;   // power_up_bit
   localparam int C_PR       = 14;   // Play (1) or record (0)
   localparam int C_RUN      = 15;   // Start (1) or stop (0)

   // Status word layout, shifted out while a command shifts in
   localparam int STAT_W     = 12;
   localparam int ST_OVF     = 0;    // overflow_flag
   localparam int ST_EOM     = 1;    // end_of_message_flag
   localparam int ST_PTR_LSB = 2;    // row_pointer_out

   // Bit counters of the serial link
   localparam int RCNT_W     = 5;
   localparam int FIDX_W     = 4;

   // Memory geometry and timing
   localparam int NUM_ROWS      = 600;
   localparam int CELLS_PER_ROW = 1600;
   localparam int SAMPLE_HZ     = 8000;
   localparam int CLK_HZ        = 20_000_000;
   localparam int US_PER_S      = 1_000_000;
   localparam int POWER_UP_DELAY_US      = 25_000;   // power_up_delay in us
   localparam int CUE_SPEEDUP   = 1600;
   localparam int PUD_CYC       = POWER_UP_DELAY_US * (CLK_HZ / US_PER_S);
   localparam int ROW_CYC       = CELLS_PER_ROW * (CLK_HZ / SAMPLE_HZ);

   localparam logic [ADDR_W-1:0] LAST_ROW = ADDR_W'(NUM_ROWS - 1);

   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_WAKE,
      ST_READY,
      ST_PLAY,
      ST_REC,
      ST_CUE
   } vrc_state_t;

endpackage : vrc_pkg

// *** hw/vrc_link_if.sv ***
`timescale 1ns/1ps
interface vrc_link_if;
   import vrc_pkg::*;

   logic [CMD_W-1:0]  word;     // Last command shifted in
   logic              full;     // Exactly one whole word was received
   logic [STAT_W-1:0] status;   // Frozen status while a frame runs

   modport link (output word, output full, input status);
   modport core (input word, input full, output status);

endinterface : vrc_link_if

// *** hw/vrc_spi_link.sv ***
`timescale 1ns/1ps
module vrc_spi_link
   import vrc_pkg::*;
(
   input  wire logic  sclk,
   input  wire logic  ss_n,
   input  wire logic  mosi,
   output logic       miso,
   output logic       miso_oe,
   vrc_link_if.link   lk
);

   logic [RCNT_W-1:0] rcnt_q;
   logic              fresh_q;
   logic [CMD_W-1:0]  sh_q;
   logic [FIDX_W-1:0] fidx_q;

   ////////////////////////////////////////////////////////////////////////
   // Frame start marker, armed while select is high
   always_ff @(posedge sclk or posedge ss_n) begin
      if (ss_n) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   // Rising edge count; kept through select high so the core can read it
   always_ff @(posedge sclk) begin
      if (fresh_q) begin
         rcnt_q <= RCNT_W'(1);
      end else if (rcnt_q != '1) begin
         rcnt_q <= rcnt_q + RCNT_W'(1);
      end
   end

   // Input sampled on rising edges, first bit ends up in bit 0
   always_ff @(posedge sclk) begin
      sh_q <= {mosi, sh_q[CMD_W-1:1]};
   end

   assign lk.word = sh_q;
   assign lk.full = (rcnt_q == RCNT_W'(CMD_W));

   ////////////////////////////////////////////////////////////////////////
   // Output driven on falling edges, low bit first, idle while deselected
   always_ff @(negedge sclk or posedge ss_n) begin
      if (ss_n) begin
         fidx_q  <= '0;
         miso    <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= 1'b1;
         miso    <= (int'(fidx_q) < STAT_W) ? lk.status[fidx_q] : 1'b0;
         if (fidx_q != '1) begin
            fidx_q <= fidx_q + FIDX_W'(1);
         end
      end
   end

endmodule : vrc_spi_link

// *** hw/vrc_top.sv ***
`timescale 1ns/1ps
module vrc_top
   import vrc_pkg::*;
#(
   parameter int PUD_CYCLES = PUD_CYC,
   parameter int ROW_CYCLES = ROW_CYC
)(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic sclk,
   input  wire logic ss_n,
   input  wire logic mosi,
   output logic      miso,
   output logic      miso_oe,
   output logic      interrupt,
   output logic      row_boundary_clock
);

   localparam int CUE_CYCLES = ROW_CYCLES / CUE_SPEEDUP;
   localparam int TMR_MAX    = (PUD_CYCLES > ROW_CYCLES) ? PUD_CYCLES
                                                         : ROW_CYCLES;
   localparam int TMR_W      = $clog2(TMR_MAX + 1);

   // Elaboration check: cue rows must last at least one clock
   if (ROW_CYCLES < CUE_SPEEDUP || PUD_CYCLES < 1) begin : g_chk
      $error("vrc_top: ROW_CYCLES or PUD_CYCLES too small");
   end

   // Valid row index inside the marker array
   function automatic logic row_ok(input logic [ADDR_W-1:0] r);
      row_ok = (int'(r) < NUM_ROWS);
   endfunction : row_ok

   ////////////////////////////////////////////////////////////////////////
   // Serial link on its own clock

   vrc_link_if lk ();

   vrc_spi_link u_link (
      .sclk    (sclk),
      .ss_n    (ss_n),
      .mosi    (mosi),
      .miso    (miso),
      .miso_oe (miso_oe),
      .lk      (lk.link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Select synchroniser and frame edges

   logic ss_s1_q;
   logic ss_s2_q;
   logic ss_s3_q;
   logic frame_start;
   logic frame_end;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ss_s1_q <= 1'b1;
         ss_s2_q <= 1'b1;
         ss_s3_q <= 1'b1;
      end else begin
         ss_s1_q <= ss_n;
         ss_s2_q <= ss_s1_q;
         ss_s3_q <= ss_s2_q;
      end
   end

   assign frame_start = ss_s3_q & ~ss_s2_q;
   assign frame_end   = ~ss_s3_q & ss_s2_q;

   ////////////////////////////////////////////////////////////////////////
   // Command capture; link word is static once select is high again

   logic             cmd_vld_q;
   logic [CMD_W-1:0] cmd_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cmd_vld_q <= 1'b0;
         cmd_q     <= '0;
      end else begin
         cmd_vld_q <= frame_end & lk.full;
         if (frame_end && lk.full) begin
            cmd_q <= lk.word;
         end
      end
   end

   // Control fields
   logic              c_mc;
   logic              c_iab;
   logic              c_pu;
   logic              c_pr;
   logic              c_run;
   logic [ADDR_W-1:0] c_addr;

   assign c_mc   = cmd_q[C_MC];
   assign c_iab  = cmd_q[C_IAB];
   assign c_pu   = cmd_q[C_PU];
   assign c_pr   = cmd_q[C_PR];
   assign c_run  = cmd_q[C_RUN];
   assign c_addr = cmd_q[ADDR_LSB +: ADDR_W];

   ////////////////////////////////////////////////////////////////////////
   // Core state shared by the processes below

   vrc_state_t        state_q;
   logic [TMR_W-1:0]  timer_q;
   logic              iab_q;
   logic [ADDR_W-1:0] row_q;
   logic              ovf_q;
   logic              eom_q;
   logic              irq_q;
   logic              row_boundary_clock_q;
   logic [STAT_W-1:0] stat_q;
   logic [STAT_W-1:0] stat_d;
   logic              eom_mark_q [NUM_ROWS];

   // Decoded requests and row timing
   logic              running;
   vrc_state_t        new_st;
   logic              start_req;
   logic              cont;
   logic              cmd_takes;
   logic [TMR_W-1:0]  row_lim;
   logic              tick;
   logic              wake_done;
   logic              row_end;
   logic              row_act;
   logic              at_last;
   logic              mark_here;
   logic              iab_eff;

   assign running = (state_q == ST_PLAY) || (state_q == ST_REC) ||
                    (state_q == ST_CUE);

   // Direction and cue select the operation
   assign new_st = c_pr ? (c_mc ? ST_CUE : ST_PLAY) : ST_REC;

   // Run requests count only once powered and settled
   assign start_req = cmd_vld_q & c_pu & c_run &
                      (running || state_q == ST_READY);

   // Same operation with address ignored just carries on
   assign cont      = start_req & c_iab & (new_st == state_q);
   assign cmd_takes = cmd_vld_q & ~cont;

   // Cue rows run at the fast rate
   assign row_lim   = (state_q == ST_CUE) ? TMR_W'(CUE_CYCLES)
                                          : TMR_W'(ROW_CYCLES);
   assign tick      = (timer_q == row_lim - TMR_W'(1));
   assign wake_done = (timer_q == TMR_W'(PUD_CYCLES - 1));
   assign row_end   = running & tick;
   assign row_act   = row_end & ~cmd_takes;
   assign at_last   = (row_q >= LAST_ROW);
   assign mark_here = row_ok(row_q) ? eom_mark_q[row_q] : 1'b0;
   assign iab_eff   = cont | iab_q;

   ////////////////////////////////////////////////////////////////////////
   // Row end outcome per operation

   logic ev_eom;
   logic ev_ovf;
   logic auto_stop;
   logic adv;
   logic mark_set;
   logic mark_clr;

   always_comb begin
      ev_eom    = 1'b0;
      ev_ovf    = 1'b0;
      auto_stop = 1'b0;
      adv       = 1'b0;
      if (row_act && state_q == ST_PLAY) begin
         if (mark_here) begin
            ev_eom    = 1'b1;
            auto_stop = 1'b1;
         end else if (at_last) begin
            ev_ovf    = 1'b1;
            auto_stop = 1'b1;
         end else begin
            adv       = iab_eff;
         end
      end else if (row_act && state_q == ST_REC) begin
         if (at_last) begin
            ev_ovf    = 1'b1;
            auto_stop = 1'b1;
         end else begin
            adv       = iab_eff;
         end
      end else if (row_act && state_q == ST_CUE) begin
         if (mark_here) begin
            ev_eom    = 1'b1;
            auto_stop = 1'b1;
            adv       = ~at_last;
         end else if (at_last) begin
            ev_ovf    = 1'b1;
            auto_stop = 1'b1;
         end else begin
            adv       = 1'b1;
         end
      end
   end

   // A recording that ends leaves its end marker on the current row
   assign mark_set = (state_q == ST_REC) & (cmd_takes | ev_ovf);
   assign mark_clr = row_act & (state_q == ST_REC) & ~ev_ovf;

   ////////////////////////////////////////////////////////////////////////
   // Operation state and row timer

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= ST_SLEEP;
         timer_q <= '0;
      end else if (cmd_takes && !c_pu) begin
         state_q <= ST_SLEEP;
         timer_q <= '0;
      end else if (cmd_takes && !c_run) begin
         if (state_q == ST_SLEEP) begin
            state_q <= ST_WAKE;
            timer_q <= '0;
         end else if (running) begin
            state_q <= ST_READY;
            timer_q <= '0;
         end
      end else if (cmd_takes && start_req) begin
         state_q <= new_st;
         timer_q <= '0;
      end else if (state_q == ST_WAKE) begin
         if (wake_done) begin
            state_q <= ST_READY;
            timer_q <= '0;
         end else begin
            timer_q <= timer_q + TMR_W'(1);
         end
      end else if (running) begin
         if (tick) begin
            timer_q <= '0;
         end else begin
            timer_q <= timer_q + TMR_W'(1);
         end
         if (auto_stop) begin
            state_q <= ST_READY;
         end
      end
   end

   // Address source held for row-end decisions
   always_ff @(posedge clock) begin
      if (!nrst) begin
         iab_q <= 1'b0;
      end else if (start_req) begin
         iab_q <= c_iab;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Row pointer

   always_ff @(posedge clock) begin
      if (!nrst) begin
         row_q <= '0;
      end else if (cmd_takes && start_req && !c_iab) begin
         row_q <= c_addr;
      end else if (adv) begin
         row_q <= row_q + ADDR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // End markers per row; a recorded row drops its old marker

   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_ROWS; i++) begin
            eom_mark_q[i] <= 1'b0;
         end
      end else if (mark_set && row_ok(row_q)) begin
         eom_mark_q[row_q] <= 1'b1;
      end else if (mark_clr && row_ok(row_q)) begin
         eom_mark_q[row_q] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flags and interrupt; a new event wins over the frame clear

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ovf_q <= 1'b0;
         eom_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (frame_start) begin
            ovf_q <= 1'b0;
            eom_q <= 1'b0;
            irq_q <= 1'b0;
         end
         if (ev_ovf) begin
            ovf_q <= 1'b1;
            irq_q <= 1'b1;
         end
         if (ev_eom) begin
            eom_q <= 1'b1;
            irq_q <= 1'b1;
         end
      end
   end

   // One-cycle pulse at each row boundary
   always_ff @(posedge clock) begin
      if (!nrst) begin
         row_boundary_clock_q <= 1'b0;
      end else begin
         row_boundary_clock_q <= row_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word, frozen while a frame is in progress

   always_comb begin
      stat_d                        = '0;
      stat_d[ST_OVF]                = ovf_q;
      stat_d[ST_EOM]                = eom_q;
      stat_d[ST_PTR_LSB +: ADDR_W]  = row_q;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         stat_q <= '0;
      end else if (ss_s2_q) begin
         stat_q <= stat_d;
      end
   end

   assign lk.status          = stat_q;
   assign interrupt          = irq_q;
   assign row_boundary_clock = row_boundary_clock_q;

endmodule : vrc_top

// *** sim/vrc_monitor.sv ***
`timescale 1ns/1ps
module vrc_monitor
   import vrc_pkg::*;
#(
   parameter int PUD_CYCLES = PUD_CYC,
   parameter int ROW_CYCLES = ROW_CYC
)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic interrupt,
   input wire logic row_boundary_clock
);
   localparam int CUE_GAP = ROW_CYCLES / CUE_SPEEDUP;
   logic [4:0]  bit_cnt_q;
   logic [2:0]  hi_cnt_q;
   logic [31:0] gap_q;
   logic        seen_q;

   ////////////////////////////////////////////////////////////////////////////
   // Rising serial edges seen in the current frame
   always_ff @(posedge sclk or posedge ss_n) begin
      if (ss_n) bit_cnt_q <= 5'h00;
      else if (bit_cnt_q != 5'h1F) bit_cnt_q <= bit_cnt_q + 5'h01;
   end
   // Core cycles with select high, saturating
   always_ff @(posedge clock) begin
      if (!nrst || !ss_n) hi_cnt_q <= 3'h0;
      else if (hi_cnt_q != 3'h7) hi_cnt_q <= hi_cnt_q + 3'h1;
   end
   // A boundary counts only once no command can restart the row timer
   always_ff @(posedge clock) begin
      if (!nrst || hi_cnt_q != 3'h7) seen_q <= 1'b0;
      else if (row_boundary_clock) seen_q <= 1'b1;
   end
   // Cycles since the last row boundary
   always_ff @(posedge clock) begin
      if (!nrst || row_boundary_clock) gap_q <= 32'h1;
      else if (gap_q != 32'hFFFFFFFF) gap_q <= gap_q + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   a_oe_idle_off:
   assert property (@(posedge clock) disable iff (!nrst) ss_n |-> !miso_oe)
      else $error("miso driven while deselected");
   a_oe_in_frame:
   assert property (@(posedge sclk) disable iff (!nrst) !ss_n |-> miso_oe)
      else $error("miso not driven in frame");
   a_pad_bits_zero:
   assert property (@(posedge sclk) disable iff (!nrst)
      (!ss_n && bit_cnt_q >= 5'h0C && bit_cnt_q < 5'h10) |-> !miso)
      else $error("status padding not zero");
   a_int_clear_frame:
   assert property (@(posedge clock) disable iff (!nrst)
      $fell(ss_n) |-> ##[1:6] !interrupt)
      else $error("interrupt not cleared by frame");
   a_int_holds_idle:
   assert property (@(posedge clock) disable iff (!nrst)
      (interrupt && hi_cnt_q == 3'h7) |=> interrupt)
      else $error("interrupt dropped without frame");
   a_row_period:
   assert property (@(posedge clock) disable iff (!nrst)
      (row_boundary_clock && seen_q) |-> (gap_q == CUE_GAP ||
      gap_q == ROW_CYCLES))
      else $error("row period wrong");
   a_rbc_single:
   assert property (@(posedge clock) disable iff (!nrst)
      row_boundary_clock |=> !row_boundary_clock)
      else $error("row pulse too long");
   a_quiet_reset:
   assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> (!interrupt && !row_boundary_clock) [*4])
      else $error("activity right after reset");

   // Main scenarios
   c_interrupt: cover property (@(posedge clock) $rose(interrupt));
   c_cue_rows: cover property (@(posedge clock)
      row_boundary_clock ##2 row_boundary_clock);
   c_full_frame: cover property (@(posedge sclk) bit_cnt_q == 5'h0F);
endmodule : vrc_monitor

// *** sim/vrc_host_model.sv ***
`timescale 1ns/1ps
module vrc_host_model (
   output logic      sclk,
   output logic      ss_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   // Link idles high, deselected; select rises after time zero so that
   // the asynchronous clears of the link always see a real edge
   initial begin
      sclk = 1'b1;
      mosi = 1'b0;
      #1;
      ss_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One frame of nb bits (16 for a command), LSB first, status on rises
   task automatic xfer(input logic [15:0] cmd, input int nb,
                       output logic [11:0] st);
      ss_n = 1'b0;
      #250;         // Lets the core freeze its status
      for (int i = 0; i < nb; i++) begin
         sclk = 1'b0;
         mosi = cmd[i];
         #3;
         sclk = 1'b1;
         if (i < 12) st[i] = miso;
         #3;
      end
      #10;
      ss_n = 1'b1;
      mosi = ~mosi;  // Stale data must not look valid
      #300;
   endtask : xfer
endmodule : vrc_host_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
   import vrc_pkg::*;
   localparam int PUD = 20;
   localparam int ROW = 3200;
   localparam logic [4:0] K_PWR = 5'h04, K_SPLAY = 5'h1C, K_PLAY = 5'h1E;
   localparam logic [4:0] K_SREC = 5'h14, K_REC = 5'h16, K_SCUE = 5'h1D;
   localparam logic [4:0] K_CUE = 5'h1F, K_STOP = 5'h06, K_HALT = 5'h02;
   logic              clock, nrst, sclk, ss_n, mosi;
   logic              miso, miso_oe, interrupt, rbc;
   logic [STAT_W-1:0] st;
   int                error_cnt, total_checks, rbc_cnt;

   vrc_top #(.PUD_CYCLES(PUD), .ROW_CYCLES(ROW)) dut_u (
      .clock(clock), .nrst(nrst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .interrupt(interrupt),
      .row_boundary_clock(rbc));
   vrc_host_model host_u (.sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) if (rbc === 1'b1) rbc_cnt++;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic send(input logic [4:0] c, input logic [9:0] a);
      @(posedge clock);
      #1;
      host_u.xfer({c, 1'b0, a}, 16, st);
      cyc(6);
   endtask : send
   task automatic wait_int(input int lim);
      int n;
      n = 0;
      while (interrupt !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
      chk(12'(interrupt), 12'h001);
   endtask : wait_int
   function automatic logic [11:0] stw(input logic o, e, input logic [9:0] p);
      return {p, e, o};
   endfunction : stw

   ////////////////////////////////////////////////////////////////////////////
   // Run commands in standby are ignored, all six named run codes tried
   task automatic t_standby;
      logic [4:0] codes [6];
      codes = '{K_SPLAY, K_PLAY, K_SREC, K_REC, K_SCUE, K_CUE};
      send(K_HALT, 10'h000);
      foreach (codes[i]) send(codes[i], 10'h155);
      cyc(ROW + 10);
      send(K_STOP, 10'h000);
      chk(st, stw(1'b0, 1'b0, 10'h000));
      chk(12'(rbc_cnt), 12'h000);
   endtask : t_standby
   // Mark row 5, then play from row 4 with a repeat before moving on
   task automatic t_play;
      send(K_PWR, 10'h000);
      cyc(PUD);
      send(K_SREC, 10'h005);
      cyc(100);
      send(K_STOP, 10'h000);
      send(K_SPLAY, 10'h004);
      cyc(ROW + 50);
      send(K_PLAY, 10'h000);
      chk(st, stw(1'b0, 1'b0, 10'h004));
      wait_int(2 * ROW + 200);
      send(K_STOP, 10'h000);
      chk(12'(st[ST_EOM]), 12'h001);
      chk(12'(interrupt), 12'h000);
   endtask : t_play
   // Cue stops past the marked row, then runs off the end
   task automatic t_cue;
      send(K_SCUE, 10'h000);
      wait_int(30);
      send(K_STOP, 10'h000);
      chk(st, stw(1'b0, 1'b1, 10'h006));
      send(K_CUE, 10'h000);
      wait_int(1400);
      send(K_STOP, 10'h000);
      chk(12'(st[ST_OVF]), 12'h001);
   endtask : t_cue
   // Record at the last row overflows and stops by itself
   task automatic t_record;
      send(K_PWR, 10'h000);
      cyc(PUD);
      send(K_PWR, 10'h000);
      cyc(2 * PUD);
      send(K_SREC, 10'h257);
      send(K_REC, 10'h000);
      chk(12'(st[ST_PTR_LSB +: ADDR_W]), 12'h257);
      wait_int(ROW + 100);
      send(K_STOP, 10'h000);
      chk(12'(st[ST_OVF]), 12'h001);
   endtask : t_record
   // Short frame is ignored; power-down stops a running playback
   task automatic t_refuse;
      int n;
      @(posedge clock);
      #1;
      host_u.xfer({K_SPLAY, 1'b0, 10'h003}, 15, st);
      cyc(6);
      send(K_SPLAY, 10'h003);
      chk(st, stw(1'b0, 1'b0, 10'h257));
      send(K_HALT, 10'h000);
      n = rbc_cnt;
      cyc(ROW + 50);
      send(K_STOP, 10'h000);
      chk(st, stw(1'b0, 1'b0, 10'h003));
      chk(12'(rbc_cnt - n), 12'h000);
   endtask : t_refuse

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   initial begin
      nrst = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      rbc_cnt = 0;
      cyc(12);
      nrst = 1'b1;
      cyc(4);
      t_standby();
      t_play();
      t_cue();
      t_record();
      t_refuse();
      final_report();
   end
   // Watchdog
   initial begin
      #2_000_000;
      error_cnt++;
      final_report();
   end
endmodule : tb

bind vrc_top vrc_monitor #(.PUD_CYCLES(PUD_CYCLES),
   .ROW_CYCLES(ROW_CYCLES)) mon_u (
   .clock(clock), .nrst(nrst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
   .miso(miso), .miso_oe(miso_oe), .interrupt(interrupt),
   .row_boundary_clock(row_boundary_clock));
